// file: hw/ssu_defs.vh
/*
  constants for the serial unit: operating modes, shift and fifo sizes,
  and the i2c rate limit expressed in cycles of the 125 MHz ref_clk.
  assumes every includer runs on ref_clk.
*/
// Overview of operation
// - polarity bit inverts serial clock idle level
// - four spi modes map polarity and phase
// - polarity and phase act only in spi mode
// - phase zero slave drives first bit at select
// - phase zero: first edge samples, second shifts
// - phase one: first edge shifts, next samples
// - spi master write starts clock despite txen
// - i2c open drain, master, slave, 400kHz
// - data changes only while i2c clock low
// - data falling with clock high is start
// - data rising with clock high is stop
// - busy set on start, cleared on stop
// - eight bits msb first plus acknowledge bit
// - held low clock stalls the master
// - master clocks ack, receiver pulls data low
// - busy or full slave leaves data high
// - master receiver withholds last acknowledge
// - clock low counted from any fall, wait high
// - start when free, lose arbitration on mismatch
`ifndef SSU_DEFS_VH
`define SSU_DEFS_VH
`define SSU_MODE_I2C       2'b10
`define SSU_MODE_SPI       2'b11
`define SSU_FIFO_WIDTH     8
`define SSU_FIFO_DEPTH     8
`define SSU_FIFO_AW        3
`define SSU_SPI_LAST_EDGE  5'd15
`define SSU_I2C_ACK_BIT    4'd8
`define SSU_IDLE_BYTE      8'hFF
`define SSU_REF_CLK_HZ     125000000
`define SSU_I2C_MAX_HZ     400000
`define SSU_I2C_MIN_HALF_CYC \
  ((`SSU_REF_CLK_HZ + 2 * `SSU_I2C_MAX_HZ - 1) / (2 * `SSU_I2C_MAX_HZ))
`endif

// file: hw/ssu_top.v
/*
  serial unit bus logic: spi master/slave shifter and i2c master with a
  receive-only addressed slave, fed by an 8-word transmit fifo.
  assumes all pin inputs are asynchronous to ref_clk and that the
  surrounding pads resolve open-drain lines from the enables.
*/
`timescale 1ns/1ns
`include "ssu_defs.vh"

module ssu_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  // drain side
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wp_q;
  reg  [AW-1:0]    rp_q;
  reg  [AW:0]      cnt_q;
  reg  [AW:0]      cnt_d;
  wire             push = in_valid & in_ready;
  wire             pop  = out_valid & out_ready;
  localparam [AW:0] FULL = DEPTH;

  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];

  always @* begin
    cnt_d = cnt_q;
    if (push && !pop) cnt_d = cnt_q + 1'b1;
    else if (pop && !push) cnt_d = cnt_q - 1'b1;
  end

  always @(posedge ref_clk) begin
    if (push) mem[wp_q] <= in_data;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      wp_q     <= {AW{1'b0}};
      rp_q     <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != FULL);
    end
  end
endmodule // ssu_fifo

module ssu_top (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // configuration
  input  wire [1:0] unit_operating_mode_field,
  input  wire       clock_idle_polarity,
  input  wire       clock_phase_select,
  input  wire       spi_master_en,
  input  wire       transmit_enable_bit,
  input  wire [7:0] spi_half_period_cycles,
  input  wire [9:0] i2c_scl_low_cycles,
  input  wire [9:0] i2c_scl_high_cycles,
  input  wire [6:0] i2c_own_address,
  input  wire       i2c_slave_en,
  input  wire       i2c_ack_en,
  // i2c commands
  input  wire       i2c_start_cmd,
  input  wire       i2c_stop_cmd,
  // shared data register write stream
  input  wire       wr_valid,
  input  wire [7:0] wr_data,
  output wire       wr_ready,
  output wire       data_register_empty_flag,
  // received byte stream
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  input  wire       rx_ready,
  // status
  output reg        i2c_bus_busy,
  output reg        i2c_arb_lost,
  output reg        i2c_ack_seen,
  // spi pins
  input  wire       spi_serial_clock_line_i,
  output reg        spi_serial_clock_line_o,
  output reg        spi_serial_clock_line_oe,
  input  wire       spi_leader_output_line_i,
  output reg        spi_leader_output_line_o,
  output reg        spi_leader_output_line_oe,
  input  wire       spi_follower_output_line_i,
  output reg        spi_follower_output_line_o,
  output reg        spi_follower_output_line_oe,
  input  wire       spi_select_line_i,
  output reg        spi_select_line_o,
  output reg        spi_select_line_oe,
  // i2c pins
  input  wire       i2c_data_line_i,
  output reg        i2c_data_line_o,
  output reg        i2c_data_line_oe,
  input  wire       i2c_clock_line_i,
  output reg        i2c_clock_line_o,
  output reg        i2c_clock_line_oe
);
  localparam [2:0] IM_IDLE = 3'd0, IM_START = 3'd1, IM_LOW = 3'd2,
                   IM_HIGH = 3'd3, IM_HOLD = 3'd4, IM_COND = 3'd5;
  localparam [31:0] MIN_HALF = `SSU_I2C_MIN_HALF_CYC;

  // pin synchronisers and edge history
  wire [5:0] pin_raw = {spi_serial_clock_line_i, spi_leader_output_line_i,
                        spi_follower_output_line_i, spi_select_line_i,
                        i2c_data_line_i, i2c_clock_line_i};
  reg  [5:0] pin_m_q;
  reg  [5:0] pin_s_q;
  reg  [5:0] pin_p_q;
  wire sck_s = pin_s_q[5];
  wire sck_p = pin_p_q[5];
  wire mosi_s = pin_s_q[4];
  wire miso_s = pin_s_q[3];
  wire ss_s = pin_s_q[2];
  wire ss_p = pin_p_q[2];
  wire sda_s = pin_s_q[1];
  wire sda_p = pin_p_q[1];
  wire scl_s = pin_s_q[0];
  wire scl_p = pin_p_q[0];

  // transmit fifo
  wire       f_valid;
  wire [7:0] f_data;
  reg        f_pop;
  ssu_fifo #(.WIDTH(`SSU_FIFO_WIDTH), .DEPTH(`SSU_FIFO_DEPTH), .AW(`SSU_FIFO_AW)) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .in_valid (wr_valid),
    .in_data  (wr_data),
    .in_ready (wr_ready),
    .out_valid(f_valid),
    .out_data (f_data),
    .out_ready(f_pop)
  );
  assign data_register_empty_flag = wr_ready;

  wire spi_mode = (unit_operating_mode_field == `SSU_MODE_SPI);
  wire i2c_mode = (unit_operating_mode_field == `SSU_MODE_I2C);

  // spi engine state
  reg       sp_busy_q;
  reg [4:0] edge_q;
  reg       sck_lvl_q;
  reg [7:0] div_q;
  reg [7:0] tx_q;
  reg [7:0] rsh_q;
  reg       out_q;
  reg       sel_hold_q;
  wire tick = (div_q == spi_half_period_cycles);
  wire m_start = spi_mode & spi_master_en & ~sp_busy_q & ~sel_hold_q & f_valid;
  wire s_fall = spi_mode & ~spi_master_en & ss_p & ~ss_s;
  wire ev = spi_master_en ? (sp_busy_q & tick)
                          : (sp_busy_q & ~ss_s & (sck_s != sck_p));
  wire lead = ~edge_q[0];
  wire setup = clock_phase_select ? lead : ~lead;
  wire sin = spi_master_en ? miso_s : mosi_s;
  wire [7:0] rcat = {rsh_q[6:0], sin};
  wire sp_done = ev & (edge_q == `SSU_SPI_LAST_EDGE);
  wire [7:0] load = f_valid ? f_data : `SSU_IDLE_BYTE;
  wire s_reload = s_fall | (sp_done & clock_phase_select & ~ss_s);

  // i2c master state
  reg [2:0] im_q;
  reg [9:0] ic_q;
  reg [3:0] bit_q;
  reg [7:0] ish_q;
  reg       dir_q;
  reg       first_q;
  reg       hi_q;
  reg       cstop_q;
  reg       msda_q;
  reg       mscl_q;
  reg       start_pend_q;
  reg       stop_pend_q;
  wire [9:0] low_lim = (i2c_scl_low_cycles < MIN_HALF[9:0]) ? MIN_HALF[9:0]
                                                            : i2c_scl_low_cycles;
  wire [9:0] high_lim = (i2c_scl_high_cycles < MIN_HALF[9:0]) ? MIN_HALF[9:0]
                                                              : i2c_scl_high_cycles;
  wire [9:0] mid_low = {1'b0, low_lim[9:1]};
  wire drv_bit = (bit_q != `SSU_I2C_ACK_BIT) & (~dir_q | first_q);
  wire rd_byte = dir_q & ~first_q;
  wire cond_start = scl_s & scl_p & sda_p & ~sda_s;
  wire cond_stop = scl_s & scl_p & ~sda_p & sda_s;
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;

  // i2c slave receiver state
  reg       sl_on_q;
  reg       sl_sel_q;
  reg       sl_adr_q;
  reg       sl_ack_q;
  reg [3:0] sl_cnt_q;
  reg [7:0] sl_sh_q;
  wire sl_match = (sl_sh_q[7:1] == i2c_own_address) & ~sl_sh_q[0] & i2c_slave_en &
                  (im_q == IM_IDLE);
  wire sl_push = i2c_mode & sl_on_q & scl_fall & ~sl_ack_q &
                 (sl_cnt_q == `SSU_I2C_ACK_BIT) & ~sl_adr_q & sl_sel_q & ~rx_valid;
  wire m_push = (im_q == IM_HIGH) & hi_q & (bit_q == `SSU_I2C_ACK_BIT) & rd_byte &
                (~scl_s | (ic_q == high_lim));

  always @* begin
    f_pop = 1'b0;
    if (spi_mode) begin
      if (m_start | (spi_master_en & sp_done & clock_phase_select & f_valid) |
          (~spi_master_en & s_reload)) f_pop = f_valid;
    end else if (i2c_mode) begin
      if ((im_q == IM_IDLE) & start_pend_q & ~i2c_bus_busy & f_valid) f_pop = 1'b1;
      if ((im_q == IM_HOLD) & (stop_pend_q | start_pend_q | ~dir_q)) begin
        f_pop = f_valid & ~stop_pend_q;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      pin_m_q <= 6'h3F;
      pin_s_q <= 6'h3F;
      pin_p_q <= 6'h3F;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end

  // spi shifter shared by master and slave roles
  always @(posedge ref_clk) begin
    if (rst || !spi_mode) begin
      sp_busy_q <= 1'b0;
      edge_q    <= 5'h00;
      sck_lvl_q <= 1'b0;
      div_q     <= 8'h00;
      tx_q      <= 8'h00;
      rsh_q     <= 8'h00;
      out_q     <= 1'b0;
      sel_hold_q <= 1'b0;
    end else begin
      div_q <= (tick | ~sp_busy_q) ? 8'h00 : div_q + 8'h01;
      sel_hold_q <= sp_busy_q;
      if (m_start | (~spi_master_en & s_reload)) begin
        sp_busy_q <= 1'b1;
        edge_q    <= 5'h00;
        sck_lvl_q <= 1'b0;
        if (clock_phase_select) tx_q <= load;
        else begin
          tx_q  <= {load[6:0], 1'b0};
          out_q <= load[7];
        end
      end else if (ev) begin
        edge_q <= edge_q + 5'h01;
        if (spi_master_en) sck_lvl_q <= ~sck_lvl_q;
        if (!setup) rsh_q <= rcat;
        else begin
          out_q <= tx_q[7];
          tx_q  <= {tx_q[6:0], 1'b0};
        end
        if (sp_done) begin
          sp_busy_q <= spi_master_en ? (clock_phase_select & f_valid) : 1'b0;
          if (spi_master_en & clock_phase_select & f_valid) begin
            edge_q <= 5'h00;
            tx_q   <= f_data;
          end
        end
      end
      if (~spi_master_en & ss_s) sp_busy_q <= 1'b0;
    end
  end

  // i2c master: bit timing, stretching, arbitration
  always @(posedge ref_clk) begin
    if (rst || !i2c_mode) begin
      im_q <= IM_IDLE;
      ic_q <= 10'h000;
      bit_q <= 4'h0;
      ish_q <= 8'h00;
      dir_q <= 1'b0;
      first_q <= 1'b0;
      hi_q <= 1'b0;
      cstop_q <= 1'b0;
      msda_q <= 1'b1;
      mscl_q <= 1'b1;
      start_pend_q <= 1'b0;
      stop_pend_q <= 1'b0;
      i2c_arb_lost <= 1'b0;
      i2c_ack_seen <= 1'b0;
    end else begin
      if (i2c_start_cmd) begin
        start_pend_q <= 1'b1;
        i2c_arb_lost <= 1'b0;
      end
      if (i2c_stop_cmd) stop_pend_q <= 1'b1;
      ic_q <= ic_q + 10'h001;
      case (im_q)
        IM_IDLE: begin
          msda_q <= 1'b1;
          mscl_q <= 1'b1;
          if (start_pend_q & ~i2c_bus_busy & f_valid) begin
            start_pend_q <= i2c_start_cmd;
            ish_q <= f_data;
            dir_q <= f_data[0];
            first_q <= 1'b1;
            msda_q <= 1'b0;
            ic_q <= 10'h000;
            im_q <= IM_START;
          end
        end
        IM_START: if (ic_q == high_lim) begin
          mscl_q <= 1'b0;
          bit_q <= 4'h0;
          ic_q <= 10'h000;
          im_q <= IM_LOW;
        end
        IM_LOW: begin
          if (ic_q == mid_low) begin
            if (bit_q == `SSU_I2C_ACK_BIT)
              msda_q <= rd_byte ? ~i2c_ack_en : 1'b1;
            else msda_q <= drv_bit ? ish_q[7] : 1'b1;
          end
          if (ic_q == low_lim) begin
            mscl_q <= 1'b1;
            hi_q <= 1'b0;
            ic_q <= 10'h000;
            im_q <= IM_HIGH;
          end
        end
        IM_HIGH: begin
          if (!hi_q) begin
            ic_q <= 10'h000;
            if (scl_s) begin
              hi_q <= 1'b1;
              if (drv_bit & msda_q & ~sda_s) begin
                i2c_arb_lost <= 1'b1;
                msda_q <= 1'b1;
                im_q <= IM_IDLE;
              end else if (bit_q == `SSU_I2C_ACK_BIT) i2c_ack_seen <= ~sda_s;
              else ish_q <= {ish_q[6:0], sda_s};
            end
          end else if (~scl_s | (ic_q == high_lim)) begin
            mscl_q <= 1'b0;
            ic_q <= 10'h000;
            bit_q <= bit_q + 4'h1;
            im_q <= (bit_q == `SSU_I2C_ACK_BIT) ? IM_HOLD : IM_LOW;
          end
        end
        IM_HOLD: begin
          ic_q <= 10'h000;
          bit_q <= 4'h0;
          if (stop_pend_q) begin
            stop_pend_q <= i2c_stop_cmd;
            cstop_q <= 1'b1;
            im_q <= IM_COND;
          end else if (start_pend_q & f_valid) begin
            start_pend_q <= i2c_start_cmd;
            cstop_q <= 1'b0;
            ish_q <= f_data;
            dir_q <= f_data[0];
            first_q <= 1'b1;
            im_q <= IM_COND;
          end else if (~dir_q & f_valid) begin
            ish_q <= f_data;
            first_q <= 1'b0;
            im_q <= IM_LOW;
          end else if (dir_q & ~rx_valid & ~start_pend_q) begin
            first_q <= 1'b0;
            im_q <= IM_LOW;
          end
        end
        IM_COND: begin
          if (mscl_q == 1'b0) begin
            if (ic_q == mid_low) msda_q <= ~cstop_q;
            if (ic_q == low_lim) begin
              mscl_q <= 1'b1;
              hi_q <= 1'b0;
            end
          end else if (!hi_q) begin
            ic_q <= 10'h000;
            hi_q <= scl_s;
          end else if (ic_q == high_lim) begin
            msda_q <= ~cstop_q;
            ic_q <= 10'h000;
            im_q <= cstop_q ? IM_IDLE : IM_START;
          end
        end
        default: im_q <= IM_IDLE;
      endcase
    end
  end

  // i2c slave receiver, bus busy tracking
  always @(posedge ref_clk) begin
    if (rst || !i2c_mode) begin
      sl_on_q <= 1'b0;
      sl_sel_q <= 1'b0;
      sl_adr_q <= 1'b0;
      sl_ack_q <= 1'b0;
      sl_cnt_q <= 4'h0;
      sl_sh_q <= 8'h00;
      i2c_bus_busy <= 1'b0;
    end else begin
      if (cond_start) i2c_bus_busy <= 1'b1;
      else if (cond_stop) i2c_bus_busy <= 1'b0;
      if (cond_start) begin
        sl_on_q <= 1'b1;
        sl_sel_q <= 1'b0;
        sl_adr_q <= 1'b1;
        sl_ack_q <= 1'b0;
        sl_cnt_q <= 4'h0;
      end else if (cond_stop) begin
        sl_on_q <= 1'b0;
        sl_ack_q <= 1'b0;
      end else if (sl_on_q) begin
        if (scl_rise & (sl_cnt_q != `SSU_I2C_ACK_BIT)) begin
          sl_sh_q <= {sl_sh_q[6:0], sda_s};
          sl_cnt_q <= sl_cnt_q + 4'h1;
        end
        if (scl_fall & (sl_cnt_q == `SSU_I2C_ACK_BIT)) begin
          if (!sl_ack_q) begin
            sl_ack_q <= 1'b1;
            if (sl_adr_q) sl_sel_q <= sl_match;
            if (sl_adr_q & ~sl_match) sl_on_q <= 1'b0;
          end else begin
            sl_ack_q <= 1'b0;
            sl_cnt_q <= 4'h0;
            sl_adr_q <= 1'b0;
          end
        end
      end
    end
  end

  // received bytes, pin drivers
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      spi_serial_clock_line_o <= 1'b0;
      spi_serial_clock_line_oe <= 1'b0;
      spi_leader_output_line_o <= 1'b0;
      spi_leader_output_line_oe <= 1'b0;
      spi_follower_output_line_o <= 1'b0;
      spi_follower_output_line_oe <= 1'b0;
      spi_select_line_o <= 1'b1;
      spi_select_line_oe <= 1'b0;
      i2c_data_line_o <= 1'b0;
      i2c_data_line_oe <= 1'b0;
      i2c_clock_line_o <= 1'b0;
      i2c_clock_line_oe <= 1'b0;
    end else begin
      if (rx_valid & rx_ready) rx_valid <= 1'b0;
      if (spi_mode & sp_done) begin
        rx_valid <= 1'b1;
        rx_data <= setup ? rsh_q : rcat;
      end else if (i2c_mode & m_push) begin
        rx_valid <= 1'b1;
        rx_data <= ish_q;
      end else if (sl_push) begin
        rx_valid <= 1'b1;
        rx_data <= sl_sh_q;
      end
      spi_serial_clock_line_o <= clock_idle_polarity ^ sck_lvl_q;
      spi_serial_clock_line_oe <= spi_mode & spi_master_en;
      spi_leader_output_line_o <= out_q;
      spi_leader_output_line_oe <= spi_mode & spi_master_en & transmit_enable_bit;
      spi_follower_output_line_o <= out_q;
      spi_follower_output_line_oe <= spi_mode & ~spi_master_en & ~ss_s & sp_busy_q;
      spi_select_line_o <= ~(sp_busy_q | sel_hold_q);
      spi_select_line_oe <= spi_mode & spi_master_en;
      i2c_data_line_oe <= i2c_mode & (~msda_q |
                          (sl_ack_q & (sl_adr_q ? sl_match : ~rx_valid)));
      i2c_clock_line_oe <= i2c_mode & ~mscl_q;
    end
  end
endmodule // ssu_top

// file: verification/ssu_top_sva.sv
/*
  ssu_chk: bus-level assertions on the ports of ssu_top.
  assumes one ref_clk domain and synchronous active-high rst.
*/
`timescale 1ns/1ns
module ssu_chk (
  // clock and reset
  input wire       ref_clk,
  input wire       rst,
  // configuration
  input wire [1:0] unit_operating_mode_field,
  input wire       clock_idle_polarity,
  input wire       spi_master_en,
  input wire       transmit_enable_bit,
  // write stream and status
  input wire       wr_valid,
  input wire       wr_ready,
  input wire       data_register_empty_flag,
  input wire       i2c_bus_busy,
  input wire       i2c_arb_lost,
  // pins
  input wire       spi_serial_clock_line_o,
  input wire       spi_serial_clock_line_oe,
  input wire       spi_select_line_o,
  input wire       i2c_data_line_i,
  input wire       i2c_data_line_o,
  input wire       i2c_data_line_oe,
  input wire       i2c_clock_line_i,
  input wire       i2c_clock_line_o,
  input wire       i2c_clock_line_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire spi_m = (unit_operating_mode_field == 2'b11) && spi_master_en;
  wire i2c_m = unit_operating_mode_field == 2'b10;

  a_open_drain:
    assert property (i2c_data_line_o == 1'b0 && i2c_clock_line_o == 1'b0)
      else $error("i2c pin driven high");
  a_spi_quiet:
    assert property ((unit_operating_mode_field != 2'b11) [*4] |-> !spi_serial_clock_line_oe)
      else $error("spi clock driven outside spi mode");
  a_idle_pol:
    assert property ((spi_m && spi_select_line_o && $stable(clock_idle_polarity)) [*4]
      |-> spi_serial_clock_line_o == clock_idle_polarity)
      else $error("spi clock idle level wrong");
  a_clk_start:
    assert property (wr_valid && wr_ready && spi_m && !transmit_enable_bit
      |-> ##[1:400] $changed(spi_serial_clock_line_o))
      else $error("spi clock did not start");
  a_busy_start:
    assert property (i2c_m && $fell(i2c_data_line_i) && i2c_clock_line_i
      && $past(i2c_clock_line_i) |-> ##[1:6] i2c_bus_busy)
      else $error("busy not set after start");
  a_free_stop:
    assert property (i2c_m && $rose(i2c_data_line_i) && i2c_clock_line_i
      && $past(i2c_clock_line_i) |-> ##[1:6] !i2c_bus_busy)
      else $error("busy not cleared after stop");
  a_arb_off:
    assert property ($rose(i2c_arb_lost) |-> ##[0:2] (!i2c_data_line_oe && !i2c_clock_line_oe))
      else $error("lines held after lost arbitration");
  a_empty_flag:
    assert property ($fell(data_register_empty_flag) |-> $past(wr_valid && wr_ready))
      else $error("empty flag dropped without a write");
endmodule // ssu_chk

bind ssu_top ssu_chk u_chk (.*);

// file: verification/ssu_partner.sv
/*
  ssu_partner: spi follower and i2c receiver on the far side.
  assumes resolved pin levels from the bench; i2c lines pulled up.
*/
`timescale 1ns/1ns
module ssu_partner (
  // spi side
  input  wire       sclk,
  input  wire       din,
  input  wire       sel_n,
  input  wire       cpol,
  input  wire       cpha,
  input  wire [7:0] tx_byte,
  output reg        dout,
  // i2c side
  input  wire       scl,
  input  wire       sda,
  input  wire       ack,
  input  wire       fight,
  output reg        scl_low,
  output reg        sda_low
);
  reg     [7:0] sh, rs, ib;
  integer       n, b;
  reg     [7:0] got[$];

  initial {dout, scl_low, sda_low, n, b} = 67'h0;
  // deselected output shows a changing pattern
  always #8 if (sel_n) dout = ~dout;
  always @(negedge sel_n) begin
    n = 0;
    sh = tx_byte;
    dout = cpha ? ~dout : sh[7];
  end
  always @(sclk) if (!sel_n) begin
    if ((sclk != cpol) ^ cpha) begin
      rs = {rs[6:0], din};
      sh = sh << 1;
      n = n + 1;
      if (n == 8) begin
        got.push_back(rs);
        n = 0;
        sh = tx_byte;
      end
    end else dout = sh[7];
  end
  // i2c: start, optional fight for the data line, stop
  always @(negedge sda) if (scl) begin
    b = 0;
    if (fight) sda_low = 1'b1;
    if (fight) sda_low <= #8000 1'b0;
  end
  always @(posedge sda) if (scl) b = 0;
  always @(posedge scl) if (b < 8) begin
    ib = {ib[6:0], sda};
    b = b + 1;
  end
  always @(negedge scl) begin
    if (b == 8 && !fight) begin
      sda_low = ack;
      b = 9;
    end else if (b == 9) begin
      sda_low = 1'b0;
      got.push_back(ib);
      b = 0;
      scl_low = 1'b1;
      scl_low <= #2000 1'b0;
    end
  end
endmodule // ssu_partner

// file: verification/tb_top.sv
/*
  tb_top: self-checking bench for ssu_top: spi formats, buffer, i2c.
  assumes ssu_partner on the far side and pull-ups on i2c lines.
*/
`timescale 1ns/1ns
module tb_top;
  // design ports
  reg        ref_clk, rst, clock_idle_polarity, clock_phase_select;
  reg        spi_master_en, transmit_enable_bit, i2c_slave_en, i2c_ack_en;
  reg        i2c_start_cmd, i2c_stop_cmd, wr_valid, rx_ready;
  reg  [1:0] unit_operating_mode_field;
  reg  [7:0] spi_half_period_cycles, wr_data;
  reg  [9:0] i2c_scl_low_cycles, i2c_scl_high_cycles;
  reg  [6:0] i2c_own_address;
  wire       wr_ready, data_register_empty_flag, rx_valid;
  wire [7:0] rx_data;
  wire       i2c_bus_busy, i2c_arb_lost, i2c_ack_seen;
  wire       spi_serial_clock_line_o, spi_serial_clock_line_oe;
  wire       spi_leader_output_line_o, spi_leader_output_line_oe;
  wire       spi_follower_output_line_o, spi_follower_output_line_oe;
  wire       spi_select_line_o, spi_select_line_oe;
  wire       i2c_data_line_o, i2c_data_line_oe, i2c_clock_line_o, i2c_clock_line_oe;
  // partner and bench state
  reg        junk, p_ack, p_fight;
  reg  [7:0] p_tx, b;
  wire       p_dout, p_scl_low, p_sda_low;
  integer    n_errors, n_tests, seed, i, k;
  reg  [7:0] exp_q[$];
  // resolved pins; a released spi clock or leader output line shows a changing pattern, a released select line reads high
  wire spi_serial_clock_line_i = spi_serial_clock_line_oe ? spi_serial_clock_line_o : junk;
  wire spi_leader_output_line_i = spi_leader_output_line_oe ? spi_leader_output_line_o : junk;
  wire spi_select_line_i = spi_select_line_oe ? spi_select_line_o : 1'b1;
  wire spi_follower_output_line_i = p_dout;
  wire i2c_data_line_i = ~(i2c_data_line_oe | p_sda_low);
  wire i2c_clock_line_i = ~(i2c_clock_line_oe | p_scl_low);

  ssu_top DUT (.*);
  ssu_partner u_p (.sclk(spi_serial_clock_line_i), .din(spi_leader_output_line_i),
    .sel_n(spi_select_line_i), .cpol(clock_idle_polarity), .cpha(clock_phase_select),
    .tx_byte(p_tx), .dout(p_dout), .scl(i2c_clock_line_i), .sda(i2c_data_line_i),
    .ack(p_ack), .fight(p_fight), .scl_low(p_scl_low), .sda_low(p_sda_low));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) junk <= ~junk;

  task chk(input [7:0] seen, input [7:0] expv);
    begin
      n_tests = n_tests + 1;
      if (seen !== expv) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: saw %h, expected %h", $time, seen, expv);
      end
    end
  endtask
  task put(input [7:0] v);
    begin
      wr_data  <= v;
      wr_valid <= 1'b1;
      @(posedge ref_clk);
      while (wr_ready !== 1'b1) @(posedge ref_clk);
      wr_valid <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task cmd(input start);
    begin
      if (start) i2c_start_cmd <= 1'b1;
      else i2c_stop_cmd <= 1'b1;
      @(posedge ref_clk);
      {i2c_start_cmd, i2c_stop_cmd} <= 2'b00;
      @(posedge ref_clk);
    end
  endtask
  function done(input integer s);
    case (s)
      0: done = rx_valid === 1'b1;
      1: done = u_p.got.size() >= k;
      2: done = i2c_arb_lost === 1'b1;
      default: done = i2c_bus_busy === 1'b0;
    endcase
  endfunction
  task await(input integer s);
    integer t;
    begin
      t = 0;
      while (!done(s) && t < 20000) begin
        @(posedge ref_clk);
        t = t + 1;
      end
      if (!done(s)) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: wait timed out", $time);
        summarize;
      end
    end
  endtask
  // compare the far side's captured bytes with the model queue
  task flush(input cmp);
    reg [7:0] v;
    begin
      while (u_p.got.size() > 0) begin
        v = u_p.got.pop_front();
        if (cmp) chk(v, exp_q.pop_front());
      end
      if (cmp) chk(exp_q.size(), 8'h00);
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    #600000;
    n_errors = n_errors + 1;
    $display("Error at %0t: watchdog expired", $time);
    summarize;
  end

  initial begin
    seed = 32'h7E9DE2F5;
    n_errors = 0;
    n_tests = 0;
    {rst, clock_idle_polarity, clock_phase_select, spi_master_en} = 4'h9;
    {transmit_enable_bit, i2c_slave_en, i2c_ack_en, i2c_start_cmd} = 4'h0;
    {i2c_stop_cmd, wr_valid, rx_ready, junk, p_ack, p_fight} = 6'h00;
    unit_operating_mode_field = 2'b00;
    {spi_half_period_cycles, wr_data, p_tx} = 24'h030000;
    {i2c_scl_low_cycles, i2c_scl_high_cycles} = {10'h09D, 10'h09D};
    i2c_own_address = 7'h11;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // one byte in each clock format; transmit enable low in modes 0 and 2
    for (i = 0; i < 4; i = i + 1) begin
      unit_operating_mode_field <= 2'b00;
      {clock_idle_polarity, clock_phase_select} <= i[1:0];
      transmit_enable_bit <= i[0];
      p_tx <= $random(seed);
      b = $random(seed);
      repeat (4) @(posedge ref_clk);
      unit_operating_mode_field <= 2'b11;
      repeat (4) @(posedge ref_clk);
      if (i[0]) exp_q.push_back(b);
      put(b);
      await(0);
      chk(rx_data, p_tx);
      rx_ready <= 1'b1;
      @(posedge ref_clk);
      rx_ready <= 1'b0;
      repeat (20) @(posedge ref_clk);
      flush(i[0]);
    end
    // fill the buffer past its depth with engines idle, then drain it
    unit_operating_mode_field <= 2'b00;
    {clock_idle_polarity, clock_phase_select, transmit_enable_bit} <= 3'h1;
    repeat (4) @(posedge ref_clk);
    for (i = 0; i < 10; i = i + 1) begin
      wr_data  <= $random(seed);
      wr_valid <= 1'b1;
      @(posedge ref_clk);
      if (wr_ready === 1'b1) exp_q.push_back(wr_data);
    end
    wr_valid <= 1'b0;
    chk(exp_q.size(), 8'h08);
    chk(data_register_empty_flag, 1'b0);
    k = 8;
    rx_ready <= 1'b1;
    unit_operating_mode_field <= 2'b11;
    await(1);
    chk(data_register_empty_flag, 1'b1);
    flush(1'b1);
    rx_ready <= 1'b0;
    // another master holds data low: arbitration is lost
    unit_operating_mode_field <= 2'b10;
    repeat (8) @(posedge ref_clk);
    p_fight = 1'b1;
    put(8'hAA);
    cmd(1'b1);
    await(2);
    chk(i2c_arb_lost, 1'b1);
    await(3);
    chk(i2c_bus_busy, 1'b0);
    p_fight = 1'b0;
    // a refused address, then an accepted address and data byte
    for (i = 0; i < 2; i = i + 1) begin
      p_ack = i[0];
      i2c_ack_en <= i[0];
      b = $random(seed);
      exp_q.push_back(8'hA4);
      put(8'hA4);
      if (i[0]) exp_q.push_back(b);
      if (i[0]) put(b);
      cmd(1'b1);
      k = i + 1;
      await(1);
      repeat (40) @(posedge ref_clk);
      chk(i2c_ack_seen, p_ack);
      chk(i2c_bus_busy, 1'b1);
      cmd(1'b0);
      await(3);
      chk(i2c_bus_busy, 1'b0);
      flush(1'b1);
    end
    summarize;
  end
endmodule // tb_top
